// *** hdl/lcdtg_sync_in.v ***
// Purpose: two-flop synchroniser for a group of external levels
// Assumes: inputs asynchronous to pclk
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module lcdtg_sync_in #(
   parameter W = 4
) (
   input  wire         pclk,    // system clock
   input  wire         presetn, // async reset, active low
   input  wire [W-1:0] d_in,    // asynchronous levels
   output reg  [W-1:0] d_out    // synchronised levels
);
   reg [W-1:0] meta_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= {W{1'b0}};
         d_out  <= {W{1'b0}};
      end else begin
         meta_r <= d_in;
         d_out  <= meta_r;
      end
   end
endmodule // lcdtg_sync_in
`default_nettype wire

// *** hdl/lcdtg_timing.v ***
// Purpose: lcd drive timing generator with standby and master/slave sync
// Assumes: apb slave, pclk 200 mhz, sync pins sampled on pclk
// Notes:   panel clock derived from pclk; no interrupts, no buffering
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lcdtg_regs.vh"
module lcdtg_timing (
   input  wire        pclk,              // apb clock
   input  wire        presetn,           // async reset, active low
   input  wire        psel,              // apb select
   input  wire        penable,           // apb enable
   input  wire        pwrite,            // apb direction
   input  wire [11:0] paddr,             // apb byte address
   input  wire [31:0] pwdata,            // apb write data
   output reg  [31:0] prdata,            // apb read data
   output reg         pready,            // apb ready
   output reg         pslverr,           // apb error
   input  wire        slave_sel,         // high selects slave mode
   input  wire        frame_start_in,    // frame start from master
   input  wire        line_clock_in,     // line clock from master
   input  wire        pol_in,            // polarity from master
   output reg         frame_start_marker,// frame start out
   output reg         frame_start_oe,    // frame start drive enable
   output reg         line_latch_clock,  // line clock out
   output reg         line_latch_oe,     // line clock drive enable
   output reg         polarity_out,      // alternating polarity out
   output reg         polarity_oe,       // polarity drive enable
   output reg         oscillator_output, // oscillator output level
   output reg         clock_out_pin,     // divided clock out
   output reg         display_on,        // panel enabled, not blanked
   output reg  [6:0]  row_index          // current row, 0..64
);

   // ==================================================================
   // synchronised pins
   wire [3:0] pins_s;
   lcdtg_sync_in #(.W(4)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d_in    ({slave_sel, frame_start_in, line_clock_in, pol_in}),
      .d_out   (pins_s)
   );
   wire slave_s = pins_s[3];
   wire fstart_s = pins_s[2];
   wire lclk_s   = pins_s[1];
   wire pol_s   = pins_s[0];

   // ==================================================================
   // registers
   reg        standby_bit_r;
   reg        display_on_bit_r;
   reg [2:0]  address_select_r;
   reg [7:0]  function_control_register_r;
   reg [4:0]  timing_mode_register_r;
   reg [4:0]  n_line_control_register_r;

   wire wr_acc = psel & penable & pwrite;
   wire [31:0] wd = pwdata;

   function addr_ok;
      input [11:0] a;
      begin
         addr_ok = (a == `LCDTG_ADR_ASEL) | (a == `LCDTG_ADR_FCTL) |
                   (a == `LCDTG_ADR_TMODE) | (a == `LCDTG_ADR_NLINE) |
                   (a == `LCDTG_ADR_STAT);
      end
   endfunction

   // standby bit: reset clears it, other config survives the reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_bit_r <= 1'b0;
      end else if (wr_acc && paddr == `LCDTG_ADR_ASEL) begin
         standby_bit_r <= wd[`LCDTG_ASEL_SLEEP];
      end
   end

   // config regs have no reset term so a hardware reset keeps them;
   // they are cleared on standby entry instead
   wire sleep_enter = wr_acc && (paddr == `LCDTG_ADR_ASEL) &&
                      wd[`LCDTG_ASEL_SLEEP] && !standby_bit_r;
   wire asel_wr_live = wr_acc && (paddr == `LCDTG_ADR_ASEL) &&
                       !standby_bit_r && !wd[`LCDTG_ASEL_SLEEP];

   always @(posedge pclk) begin
      if (sleep_enter) begin
         display_on_bit_r            <= 1'b0;
         address_select_r            <= 3'h0;
         function_control_register_r <= 8'h00;
         timing_mode_register_r      <= 5'h00;
         n_line_control_register_r   <= 5'h00;
      end else if (wr_acc) begin
         if (asel_wr_live) begin
            // a wake write never reaches here: its display/rno dropped
            display_on_bit_r <= wd[`LCDTG_ASEL_DSPON];
            address_select_r <= wd[`LCDTG_ASEL_RNO_HI:0];
         end
         if (paddr == `LCDTG_ADR_FCTL && !standby_bit_r)
            function_control_register_r <= wd[`LCDTG_FCTL_HI:0];
         if (paddr == `LCDTG_ADR_TMODE && !standby_bit_r)
            timing_mode_register_r <= wd[`LCDTG_TMODE_WAVE_HI:0];
         if (paddr == `LCDTG_ADR_NLINE && !standby_bit_r)
            n_line_control_register_r <= wd[`LCDTG_NLINE_HI:0];
      end
   end

   // ==================================================================
   // duty and division decode
   wire [2:0] duty_sel = function_control_register_r[`LCDTG_FCTL_DUTY_HI:0];
   wire [2:0] div_sel  = timing_mode_register_r[`LCDTG_TMODE_DIV_HI:0];
   wire [1:0] wave_sel =
      timing_mode_register_r[`LCDTG_TMODE_WAVE_HI:`LCDTG_TMODE_WAVE_LO];

   reg [6:0] duty_lines;
   always @* begin
      case (duty_sel)
         3'h0:    duty_lines = 7'd32;
         3'h1:    duty_lines = 7'd34;
         3'h2:    duty_lines = 7'd36;
         3'h3:    duty_lines = 7'd48;
         3'h4:    duty_lines = 7'd50;
         3'h5:    duty_lines = 7'd64;
         default: duty_lines = 7'd66;
      endcase
   end

   // base line period for ratio one: frame at 80 hz over 64 lines, counted
   // in 200 mhz pclk cycles; duty correction keeps frame rate fixed
   localparam [`LCDTG_CNT_W-1:0] BASE_LINE =
      (`LCDTG_PCLK_MHZ * 1000000) /
      (`LCDTG_FRAME_HZ * `LCDTG_BASE_LINES);
   // line period = base * 64 / duty (duty correction) / division ratio
   reg [`LCDTG_CNT_W-1:0] line_per;
   reg [`LCDTG_CNT_W+7:0] scaled;
   always @* begin
      scaled = (BASE_LINE * `LCDTG_BASE_LINES) / duty_lines;
      case (div_sel)
         3'h0:    line_per = scaled[`LCDTG_CNT_W-1:0];            // 1
         3'h1:    line_per = scaled[`LCDTG_CNT_W:1];              // 2
         3'h2:    line_per = scaled[`LCDTG_CNT_W-2:0] << 1;       // 1/2
         3'h3:    line_per = scaled[`LCDTG_CNT_W-1:0] * 3;        // 1/3
         3'h4:    line_per = scaled[`LCDTG_CNT_W-3:0] << 2;       // 1/4
         3'h5:    line_per = scaled[`LCDTG_CNT_W-1:0] * 6;        // 1/6
         default: line_per = scaled[`LCDTG_CNT_W-4:0] << 3;       // 1/8
      endcase
   end

   // ==================================================================
   // master scan
   reg [`LCDTG_CNT_W-1:0] tick_r;
   reg [6:0] line_r;
   reg       frame_pol_r;
   reg [4:0] nline_cnt_r;
   reg       nline_pol_r;
   wire      run = !standby_bit_r;
   wire      line_end = (tick_r >= line_per - 1'b1);
   wire      half     = (tick_r >= {1'b0, line_per[`LCDTG_CNT_W-1:1]});
   wire      last_line = (line_r == duty_lines - 7'd1);
   wire [4:0] n_val = (n_line_control_register_r == 5'h00) ?
                      5'h01 : n_line_control_register_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_r      <= {`LCDTG_CNT_W{1'b0}};
         line_r      <= 7'h00;
         frame_pol_r <= 1'b0;
         nline_cnt_r <= 5'h00;
         nline_pol_r <= 1'b0;
      end else if (!run) begin
         tick_r      <= {`LCDTG_CNT_W{1'b0}};
         line_r      <= 7'h00;
         frame_pol_r <= 1'b0;
         nline_cnt_r <= 5'h00;
         nline_pol_r <= 1'b0;
      end else if (line_end) begin
         tick_r <= {`LCDTG_CNT_W{1'b0}};
         line_r <= last_line ? 7'h00 : line_r + 7'h01;
         if (last_line)
            frame_pol_r <= ~frame_pol_r;
         if (nline_cnt_r >= n_val - 5'h01) begin
            nline_cnt_r <= 5'h00;
            nline_pol_r <= ~nline_pol_r;
         end else begin
            nline_cnt_r <= nline_cnt_r + 5'h01;
         end
      end else begin
         tick_r <= tick_r + 1'b1;
      end
   end

   wire m_lclk = half;
   reg  m_pol;
   always @* begin
      case (wave_sel)
         `LCDTG_WAVE_A: m_pol = m_lclk;
         `LCDTG_WAVE_B: m_pol = frame_pol_r;
         `LCDTG_WAVE_C: m_pol = nline_pol_r;
         default:       m_pol = nline_pol_r ^ frame_pol_r;
      endcase
   end

   // ==================================================================
   // slave line tracking, duty ignored
   reg       lclk_d_r;
   reg [6:0] s_line_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lclk_d_r <= 1'b0;
         s_line_r <= 7'h00;
      end else begin
         lclk_d_r <= lclk_s;
         if (!run)
            s_line_r <= 7'h00;
         else if (lclk_s && !lclk_d_r)
            s_line_r <= fstart_s ? 7'h00 : s_line_r + 7'h01;
      end
   end

   // ==================================================================
   // outputs, all registered
   reg [2:0] osc_div_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_start_marker <= 1'b0;
         frame_start_oe     <= 1'b0;
         line_latch_clock   <= 1'b0;
         line_latch_oe      <= 1'b0;
         polarity_out       <= 1'b0;
         polarity_oe        <= 1'b0;
         oscillator_output  <= 1'b0;
         clock_out_pin      <= 1'b0;
         display_on         <= 1'b0;
         row_index          <= 7'h00;
         osc_div_r          <= 3'h0;
      end else begin
         osc_div_r <= run ? osc_div_r + 3'h1 : 3'h0;
         oscillator_output <= run ? osc_div_r[2] : 1'b1;
         clock_out_pin     <= run ? osc_div_r[2] : 1'b0;
         frame_start_oe <= !slave_s;
         line_latch_oe  <= !slave_s;
         polarity_oe    <= !slave_s;
         frame_start_marker <= run && !slave_s && (line_r == 7'h00);
         line_latch_clock   <= run && !slave_s && m_lclk;
         polarity_out       <= run && !slave_s && m_pol;
         display_on <= run && display_on_bit_r;
         if (slave_s) begin
            display_on <= run && display_on_bit_r && (s_line_r < 7'd65);
            row_index  <= (s_line_r < 7'd65) ? s_line_r : 7'd64;
         end else begin
            row_index  <= (line_r < 7'd65) ? line_r : 7'd64;
            if (line_r >= 7'd65)
               display_on <= 1'b0;
         end
         if (slave_s)
            polarity_out <= 1'b0;
      end
   end

   // ==================================================================
   // apb read path, no wait states
   reg [31:0] rd_v;
   always @* begin
      rd_v = 32'h0000_0000;
      case (paddr)
         `LCDTG_ADR_ASEL: begin
            rd_v[`LCDTG_ASEL_SLEEP] = standby_bit_r;
            rd_v[`LCDTG_ASEL_DSPON] = display_on_bit_r;
            rd_v[`LCDTG_ASEL_RNO_HI:0] = address_select_r;
         end
         `LCDTG_ADR_FCTL:  rd_v[7:0] = function_control_register_r;
         `LCDTG_ADR_TMODE: rd_v[4:0] = timing_mode_register_r;
         `LCDTG_ADR_NLINE: rd_v[4:0] = n_line_control_register_r;
         `LCDTG_ADR_STAT: rd_v[8:0] = {slave_s, frame_pol_r, line_r};
         default:         rd_v = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok(paddr);
         prdata  <= (psel && !penable && !pwrite) ? rd_v : 32'h0000_0000;
      end
   end

endmodule // lcdtg_timing
`default_nettype wire

// *** pkg/lcdtg_regs.vh ***
// Purpose: constants of the lcd drive timing generator
// Assumes: apb byte addressing, 32-bit data
// Notes:   offsets, field positions, waveform codes and timing constants; no logic here
`ifndef LCDTG_REGS_VH
`define LCDTG_REGS_VH

// =====================================================================
// register offsets (byte addresses)
`define LCDTG_ADR_ASEL      12'h000
`define LCDTG_ADR_FCTL      12'h004
`define LCDTG_ADR_TMODE     12'h008
`define LCDTG_ADR_NLINE     12'h00C
`define LCDTG_ADR_STAT      12'h010

// =====================================================================
// fields
`define LCDTG_ASEL_SLEEP    6
`define LCDTG_ASEL_DSPON    5
`define LCDTG_ASEL_RNO_HI   2
`define LCDTG_FCTL_DUTY_HI  2
`define LCDTG_FCTL_HI       7
`define LCDTG_TMODE_DIV_HI  2
`define LCDTG_TMODE_WAVE_LO 3
`define LCDTG_TMODE_WAVE_HI 4
`define LCDTG_NLINE_HI      4

// =====================================================================
// waveform codes
`define LCDTG_WAVE_A      2'h0
`define LCDTG_WAVE_B      2'h1
`define LCDTG_WAVE_C      2'h2
`define LCDTG_WAVE_CX     2'h3

// =====================================================================
// timing: base line period with ratio one counted in pclk, not the 500 khz reference
// 500 khz / (80 hz * 64 lines) = ~98 clocks per line, 2 us each
`define LCDTG_REF_KHZ     500
`define LCDTG_FRAME_HZ    80
`define LCDTG_PCLK_MHZ    200
`define LCDTG_BASE_LINES  64
`define LCDTG_CNT_W       20

`endif

// *** tb/lcd_drive_timing_standby_sync_tb.sv ***
// Purpose: self-checking bench of the lcd drive timing generator
// Assumes: apb answer one cycle after setup, pclk 200 mhz
// Notes:   ratio 2 keeps the line period short enough to watch
`timescale 1ns/10ps
`default_nettype none
`include "lcdtg_regs.vh"
module lcd_drive_timing_standby_sync_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        slave_sel = 1'b0;
   logic        link_en = 1'b0;
   logic [31:0] rd;
   logic        er;
   wire  [31:0] prdata;
   wire         pready, pslverr, fstart_w, lclk_w, pol_w;
   wire         fsm, fso, llc, llo, pol, polo, osc, cko, dsp;
   wire  [6:0]  row;
   integer      error_cnt = 0;
   integer      tests_run = 0;
   integer      i;
   always #2.5 pclk = ~pclk;
   lcdtg_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slave_sel(slave_sel), .frame_start_in(fstart_w),
      .line_clock_in(lclk_w), .pol_in(pol_w),
      .frame_start_marker(fsm), .frame_start_oe(fso),
      .line_latch_clock(llc), .line_latch_oe(llo), .polarity_out(pol),
      .polarity_oe(polo), .oscillator_output(osc), .clock_out_pin(cko),
      .display_on(dsp), .row_index(row));
   lcdtg_master_model u_link (.en(link_en), .fstart(fstart_w),
      .lclk(lclk_w), .pol(pol_w));
   // =================================================================
   // tasks
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 50);
         rd = prdata;
         er = pslverr;
         if (n >= 50)
            error_cnt = error_cnt + 1;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task reset_pulse;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // =================================================================
   // tests
   initial begin
      reset_pulse;
      for (i = 0; i < 7; i++) begin
         apb(1'b1, `LCDTG_ADR_FCTL, i);
         apb(1'b0, `LCDTG_ADR_FCTL, 32'h0);
         check(rd, i);
         apb(1'b1, `LCDTG_ADR_TMODE, i | ((i & 3) << 3));
         apb(1'b0, `LCDTG_ADR_TMODE, 32'h0);
         check(rd, i | ((i & 3) << 3));
      end
      apb(1'b1, `LCDTG_ADR_NLINE, 32'h1F);
      apb(1'b0, `LCDTG_ADR_NLINE, 32'h0);
      check(rd, 32'h1F);
      apb(1'b0, 12'h020, 32'h0);
      check(rd, 32'h0);
      check(er, 1'b1);
      $display("registers test done");
      apb(1'b1, `LCDTG_ADR_FCTL, 32'h5);
      apb(1'b1, `LCDTG_ADR_TMODE, 32'h1);
      apb(1'b1, `LCDTG_ADR_ASEL, 32'h20);
      repeat (25000) @(posedge pclk);
      check({dsp, llo, fso, polo}, 4'hF);
      apb(1'b1, `LCDTG_ADR_TMODE, 32'h9);
      repeat (20) @(posedge pclk);
      check(pol, 1'b0);
      $display("master scan test done");
      apb(1'b1, `LCDTG_ADR_ASEL, 32'h0);
      apb(1'b1, `LCDTG_ADR_ASEL, 32'h40);
      repeat (20) @(posedge pclk);
      check({osc, cko, llc, fsm, pol, dsp}, 6'h20);
      for (i = 1; i < 4; i++) begin
         apb(1'b0, i * 4, 32'h0);
         check(rd, 32'h0);
      end
      apb(1'b0, `LCDTG_ADR_ASEL, 32'h0);
      check(rd, 32'h40);
      apb(1'b1, `LCDTG_ADR_ASEL, 32'h27);
      apb(1'b0, `LCDTG_ADR_ASEL, 32'h0);
      check(rd, 32'h0);
      check({row, pol}, 8'h00);
      $display("standby test done");
      apb(1'b1, `LCDTG_ADR_ASEL, 32'h40);
      reset_pulse;
      apb(1'b0, `LCDTG_ADR_ASEL, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, `LCDTG_ADR_FCTL, 32'h3);
      reset_pulse;
      apb(1'b0, `LCDTG_ADR_FCTL, 32'h0);
      check(rd, 32'h3);
      $display("reset test done");
      apb(1'b1, `LCDTG_ADR_FCTL, 32'h5);
      apb(1'b1, `LCDTG_ADR_TMODE, 32'h1);
      slave_sel <= 1'b1;
      link_en <= 1'b1;
      repeat (400) @(posedge pclk);
      check({llo, fso, polo}, 3'h0);
      check(row < 7'd3, 1'b1);
      link_en <= 1'b0;
      $display("slave test done");
      final_report;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt = error_cnt + 1;
      final_report;
   end
endmodule // lcd_drive_timing_standby_sync_tb
`default_nettype wire

// *** tb/lcdtg_master_model.sv ***
// Purpose: master chip model feeding sync signals to a slave
// Assumes: line clock period 160 ns, unrelated to pclk
// Notes:   released lines show the inverse of their last level
`timescale 1ns/10ps
`default_nettype none
module lcdtg_master_model #(
   parameter int LINES = 3
) (
   input  wire logic en,  // frames run while high
   output wire logic fstart, // frame start
   output wire logic lclk,   // line clock
   output wire logic pol  // polarity
);
   logic   f_r = 1'b0;
   logic   c_r = 1'b0;
   logic   p_r = 1'b0;
   integer i;
   assign fstart = en ? f_r : ~f_r;
   assign lclk   = en ? c_r : ~c_r;
   assign pol = en ? p_r : ~p_r;
   // line clock runs on without a gap between frames
   always begin
      wait (en);
      for (i = 0; i < LINES; i++) begin
         f_r = (i == 0);
         #80 c_r = 1'b1;
         #80 c_r = 1'b0;
      end
      f_r = 1'b0;
      p_r = ~p_r;
   end
endmodule // lcdtg_master_model
`default_nettype wire

// *** tb/lcdtg_timing_sva.sv ***
// Purpose: port checker for the lcd drive timing generator
// Assumes: apb writes take effect at the access edge with pready high
// Notes:   standby and waveform state are tracked from apb traffic
`timescale 1ns/10ps
`default_nettype none
`include "lcdtg_regs.vh"
module lcdtg_timing_sva (
   input wire logic        pclk,               // clock
   input wire logic        presetn,            // reset, active low
   input wire logic        psel,               // apb select
   input wire logic        penable,            // apb enable
   input wire logic        pwrite,             // apb direction
   input wire logic [11:0] paddr,              // apb address
   input wire logic [31:0] pwdata,             // apb write data
   input wire logic        pready,             // apb ready
   input wire logic        pslverr,            // apb error
   input wire logic        slave_sel,          // slave select pin
   input wire logic        frame_start_marker, // frame start
   input wire logic        frame_start_oe,     // frame start enable
   input wire logic        line_latch_clock,   // line clock
   input wire logic        line_latch_oe,      // line clock enable
   input wire logic        polarity_out,       // polarity
   input wire logic        polarity_oe,        // polarity enable
   input wire logic        oscillator_output,  // oscillator level
   input wire logic        clock_out_pin,      // clock out
   input wire logic        display_on,         // panel enabled
   input wire logic [6:0]  row_index           // current row
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =================================================================
   // tracking
   logic       ap_wr;
   logic       sleep_r;
   logic [1:0] wave_r;
   logic [3:0] age_r;
   assign ap_wr = psel & penable & pready & pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_r <= 1'b0;
         age_r   <= 4'h0;
      end else begin
         if (ap_wr && paddr == `LCDTG_ADR_ASEL)
            sleep_r <= pwdata[`LCDTG_ASEL_SLEEP];
         if (ap_wr)
            age_r <= 4'h0;
         else if (age_r != 4'hF)
            age_r <= age_r + 4'h1;
      end
   end
   // mode survives reset, so this copy is never cleared by it
   always_ff @(posedge pclk) begin
      if (ap_wr && paddr == `LCDTG_ADR_ASEL && pwdata[`LCDTG_ASEL_SLEEP])
         wave_r <= 2'h0;
      else if (ap_wr && paddr == `LCDTG_ADR_TMODE && !sleep_r)
         wave_r <= pwdata[`LCDTG_TMODE_WAVE_HI:`LCDTG_TMODE_WAVE_LO];
   end
   sequence sleep_enter;
      ap_wr && paddr == `LCDTG_ADR_ASEL && pwdata[`LCDTG_ASEL_SLEEP];
   endsequence
   sequence sleep_exit;
      ap_wr && paddr == `LCDTG_ADR_ASEL && !pwdata[`LCDTG_ASEL_SLEEP]
      && sleep_r;
   endsequence
   // =================================================================
   // assertions
   chk_apb_ready: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   chk_unmapped_err: assert property (psel && !penable && paddr > 12'h010
      |=> pslverr && pready) else $error("unmapped access not refused");
   chk_wave_a_equal: assert property (wave_r == 2'h0 && !sleep_r
      && age_r == 4'hF && !slave_sel && !$past(slave_sel, 5)
      |-> polarity_out == line_latch_clock) else $error("polarity differs");
   chk_sleep_clocks: assert property (sleep_enter
      |-> ##[1:16] (oscillator_output && !clock_out_pin))
      else $error("clocks not stopped in standby");
   chk_sleep_sync_low: assert property (sleep_r && age_r == 4'hF
      |-> !frame_start_marker && !line_latch_clock && !polarity_out
      && !display_on) else $error("sync outputs not low in standby");
   chk_wake_row: assert property (sleep_exit
      |-> ##[1:16] (row_index == 7'h00 && !polarity_out))
      else $error("scan not restarted after standby");
   chk_slave_release: assert property (slave_sel && $past(slave_sel, 5)
      |-> !frame_start_oe && !line_latch_oe && !polarity_oe)
      else $error("slave drives sync pins");
   chk_master_drive: assert property (!slave_sel && !$past(slave_sel, 5)
      && !sleep_r && age_r == 4'hF
      |-> frame_start_oe && line_latch_oe && polarity_oe)
      else $error("master not driving sync pins");
   chk_row_limit: assert property (display_on |-> row_index <= 7'h40)
      else $error("row beyond 65 lines");
   chk_frame_line0: assert property (frame_start_marker && frame_start_oe
      |-> row_index == 7'h00) else $error("frame start outside line 0");
   chk_display_on_bit_off: assert property (ap_wr && paddr == `LCDTG_ADR_ASEL
      && !pwdata[`LCDTG_ASEL_DSPON] |-> ##[1:8] !display_on)
      else $error("display not off");
endmodule // lcdtg_timing_sva
bind lcdtg_timing lcdtg_timing_sva u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .slave_sel(slave_sel), .frame_start_marker(frame_start_marker),
   .frame_start_oe(frame_start_oe), .line_latch_clock(line_latch_clock),
   .line_latch_oe(line_latch_oe), .polarity_out(polarity_out),
   .polarity_oe(polarity_oe), .oscillator_output(oscillator_output),
   .clock_out_pin(clock_out_pin), .display_on(display_on),
   .row_index(row_index));
`default_nettype wire
